// >>> dct_pkg.sv
`default_nettype none
package dct_pkg;
  // register word indices on the bus (byte address / 4); 0xff34/0xff35 printed, not multiples of four, so they are indices
  localparam logic [15:0] IDX_MODE    = 16'hff34;
  localparam logic [15:0] IDX_CTRL    = 16'hff35;
  localparam logic [15:0] IDX_COUNT   = 16'hff36;
  localparam logic [15:0] IDX_CMP0    = 16'hff37;
  localparam logic [15:0] IDX_CMP1    = 16'hff38;
  localparam logic [15:0] IDX_OUTCTL  = 16'hff39;
  localparam logic [15:0] IDX_CLKSEL  = 16'hff3a;
  localparam logic [15:0] IDX_EDGESEL = 16'hff3b;
  localparam logic [15:0] IDX_NOISE   = 16'hff3c;
  localparam logic [15:0] IDX_COUNT2  = 16'hff3d;
  localparam logic [15:0] IDX_CMP2    = 16'hff3e;
  localparam logic [15:0] IDX_CMP3    = 16'hff3f;
  localparam int          ADDR_W      = 18;

  // count control and overflow bit positions
  localparam int CE_BIT   = 1;
  localparam int OVF_BIT  = 0;
  localparam int CE3_BIT  = 3;
  localparam int SECOND_OVERFLOW_FLAG_BIT = 2;
  localparam logic [7:0] CTRL_MASK = 8'h0f;

  // clock select codes
  localparam logic [2:0] CLK_DIV4  = 3'h0;
  localparam logic [2:0] CLK_DIV64 = 3'h4;
  localparam logic [2:0] CLK_EXT   = 3'h5;
  localparam int         PRESC_W   = 6;

  // output mode nibble codes (mode1, mode0, clr1, clr0)
  localparam logic [3:0] OM_TOG_OVF  = 4'h0;
  localparam logic [3:0] OM_TOG_C0   = 4'h1;
  localparam logic [3:0] OM_TOG_C1   = 4'h2;
  localparam logic [3:0] OM_PWM0     = 4'h4;
  localparam logic [3:0] OM_PPG0     = 4'h6;
  localparam logic [3:0] OM_PWM1     = 4'h8;
  localparam logic [3:0] OM_PPG1     = 4'h9;
  localparam logic [3:0] OM_PWM_BOTH = 4'hc;

  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [15:0] CNT_FULL  = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // one channel's decoded output behaviour
  typedef struct packed {
    logic pwm;   // pwm or pulse-generator style
    logic programmable_pulse_mode;
    logic clr0;
    logic clr1;
  } dct_mode_s;

  typedef enum logic [1:0] {
    DCT_EDGE_FALL,
    DCT_EDGE_RISE,
    DCT_EDGE_NONE,
    DCT_EDGE_BOTH
  } dct_edge_e;

  // decode an output-mode nibble; prohibited codes fall back to toggle-on-overflow
  function automatic dct_mode_s dct_decode(input logic [3:0] code, input logic ch);
    dct_mode_s m;
    m = '0;
    unique case (code)
      OM_TOG_C0:   m.clr0 = 1'b1;
      OM_TOG_C1:   m.clr1 = 1'b1;
      OM_PWM0:     m.pwm  = !ch;
      OM_PPG0: begin
        m.pwm  = !ch;
        m.programmable_pulse_mode  = !ch;
        m.clr1 = 1'b1;
      end
      OM_PWM1:     m.pwm  = ch;
      OM_PPG1: begin
        m.pwm  = ch;
        m.programmable_pulse_mode  = ch;
        m.clr0 = 1'b1;
      end
      OM_PWM_BOTH: m.pwm  = 1'b1;
      default:     m = '0;
    endcase
    return m;
  endfunction
endpackage
`default_nettype wire

// >>> dct_prescaler.sv
`default_nettype none
// ****************************************************
// shared time base and count clock selection
// ****************************************************
module dct_prescaler
  import dct_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  // control
  input  wire logic       i_run,
  input  wire logic [2:0] i_select,
  input  wire logic       i_ext_tick,
  // count enable pulse
  output logic            o_tick
);
  logic [PRESC_W-1:0] base_reg;

  // shared time base; runs only while a counter is enabled
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_run) begin
      base_reg <= '0;
    end else begin
      base_reg <= base_reg + 1'b1;
    end
  end

  always_comb begin
    o_tick = 1'b0;
    if (i_select == CLK_EXT) begin
      o_tick = i_ext_tick;
    end else if (i_select <= CLK_DIV64) begin
      o_tick = i_run && (base_reg[i_select +: 2] == 2'b11)
               && ((base_reg & ((6'h01 << i_select) - 6'h01)) == 6'h00) && base_reg[i_select+1];
    end
  end
endmodule
`default_nettype wire

// >>> dct_channel.sv
`default_nettype none
// ****************************************************
// one compare channel with pin output control
// ****************************************************
module dct_channel
  import dct_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // from counter
  input  wire logic        i_match,
  input  wire logic        i_overflow,
  input  wire logic        i_stop,
  // configuration
  input  wire logic        i_pwm,
  input  wire logic        i_ppg,
  input  wire logic        i_enable,
  input  wire logic        i_level,
  // pin
  output logic             o_pin
);
  logic state_reg;
  logic pin_reg;
  logic fired_reg;

  // raw waveform: toggle, or set on overflow and reset on first match
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= 1'b0;
      fired_reg <= 1'b0;
    end else if (i_stop) begin
      state_reg <= state_reg;   // level held while stopped
    end else if (i_pwm) begin
      // only the first match per cycle ends the pulse
      if (i_overflow && !i_ppg) begin
        state_reg <= 1'b1;
        fired_reg <= 1'b0;
      end else if (i_match && !fired_reg) begin
        state_reg <= 1'b0;
        fired_reg <= 1'b1;
      end else if (i_ppg && i_overflow) begin
        state_reg <= 1'b1;
        fired_reg <= 1'b0;
      end
    end else if (i_match) begin
      state_reg <= !state_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pin_reg <= 1'b1;
    end else if (!i_enable) begin
      pin_reg <= !i_level;
    end else if (i_pwm) begin
      pin_reg <= state_reg ^ i_level;
    end else begin
      pin_reg <= !(state_reg ^ i_level);
    end
  end

  assign o_pin = pin_reg;
endmodule
`default_nettype wire

// >>> dct_timer.sv
`default_nettype none
// What this block does
// - low three select bits clock this counter; bits four to six the second.
// - codes 0-4 pick system clock over 4..64, code 5 the pin for this counter only.
// - counter read-only sixteen-bit word; reset gives zero, stopped.
// - compare 0 or 1 equal raises channel request and output match.
// - four sixteen-bit compare registers, read and write.
// - selected edge on external pin raises external request.
// - toggle modes clear on overflow, compare 0 or compare 1.
// - mode nibble selects pwm or pulse generator per output.
// - control register holds both enables and overflow flags; top nibble zero.
// - disabled output holds inverse of its level bit.
// - level bit meaning flips between toggle and pwm.
// - setting enable loads one on first count clock.
// - clearing enable zeroes counter at once, stops matches.
// - writing one to a set enable changes nothing.
// - wrap from all ones sets overflow flag.
// - overflow flag cleared only by software write.
// - match clear holds value until next count clock.
// - restart after stop always begins at one.
// - first selector picks five divisions or the pin; the second only the divisions.
// - pin sampled at system clock or a quarter of it.
// - toggle mode inverts a pin on its own match.
module dct_timer
  import dct_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // pins
  input  wire logic              i_external_count_input,
  output logic                   o_timer_output_0,
  output logic                   o_timer_output_1,
  // request pulses
  output logic                   o_compare0_irq,
  output logic                   o_compare1_irq,
  output logic                   o_external_edge_irq
);
  // ****************************************************
  // registers
  // ****************************************************
  logic [7:0]  mode_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  outctl_reg;
  logic [7:0]  clksel_reg;
  logic [1:0]  edgesel_reg;
  logic        noise_reg;
  logic [15:0] count_reg;
  logic [15:0] cmp0_reg;
  logic [15:0] cmp1_reg;
  logic [15:0] count2_reg;
  logic [15:0] cmp2_reg;
  logic [15:0] cmp3_reg;
  logic        fresh_reg;
  logic        fresh2_reg;
  logic        clr_pend_reg;
  logic        irq0_reg;
  logic        irq1_reg;
  logic        irqx_reg;

  // bus state
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // ****************************************************
  // external pin sampling and edge detection
  // ****************************************************
  logic       pin_s1_reg;
  logic       pin_s2_reg;
  logic       pin_q_reg;
  logic       pin_prev_reg;
  logic [1:0] quarter_reg;
  logic       pin_rise;
  logic       pin_fall;
  logic       pin_edge;

  // two-stage synchroniser, second stage feeds the sampler only
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= i_external_count_input;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // sample at full or quarter rate
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      quarter_reg  <= '0;
      pin_q_reg    <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      quarter_reg <= quarter_reg + 2'h1;
      if (!noise_reg || quarter_reg == 2'h3) begin
        pin_q_reg <= pin_s2_reg;
      end
      pin_prev_reg <= pin_q_reg;
    end
  end

  assign pin_rise = pin_q_reg && !pin_prev_reg;
  assign pin_fall = !pin_q_reg && pin_prev_reg;

  always_comb begin
    unique case (dct_edge_e'(edgesel_reg))
      DCT_EDGE_FALL: pin_edge = pin_fall;
      DCT_EDGE_RISE: pin_edge = pin_rise;
      DCT_EDGE_NONE: pin_edge = 1'b0;
      DCT_EDGE_BOTH: pin_edge = pin_rise || pin_fall;
    endcase
  end

  // ****************************************************
  // count clocks for both counters
  // ****************************************************
  logic tick;
  logic tick2;
  logic ce;
  logic ce2;

  assign ce  = ctrl_reg[CE_BIT];
  assign ce2 = ctrl_reg[CE3_BIT];

  dct_prescaler u_presc (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_run      (ce || ce2),
    .i_select   (clksel_reg[2:0]),
    .i_ext_tick (pin_edge),
    .o_tick     (tick)
  );

  dct_prescaler u_presc2 (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_run      (ce || ce2),
    .i_select   (clksel_reg[6:4]),
    .i_ext_tick (1'b0),
    .o_tick     (tick2)
  );

  // ****************************************************
  // main counter
  // ****************************************************
  dct_mode_s m0;
  dct_mode_s m1;
  logic      match0;
  logic      match1;
  logic      wrap;
  logic      clr_src;

  assign m0 = dct_decode(mode_reg[3:0], 1'b0);
  assign m1 = dct_decode(mode_reg[3:0], 1'b1);
  assign match0  = ce && tick && !fresh_reg && (count_reg + 16'h0001 == cmp0_reg) && !clr_pend_reg;
  assign match1  = ce && tick && !fresh_reg && (count_reg + 16'h0001 == cmp1_reg) && !clr_pend_reg;
  assign wrap    = ce && tick && !fresh_reg && !clr_pend_reg && count_reg == CNT_FULL;
  assign clr_src = (m0.clr0 && match0) || (m0.clr1 && match1);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      count_reg    <= CNT_ZERO;
      fresh_reg    <= 1'b1;
      clr_pend_reg <= 1'b0;
    end else if (!ce) begin
      count_reg    <= CNT_ZERO;
      fresh_reg    <= 1'b1;
      clr_pend_reg <= 1'b0;
    end else if (tick) begin
      if (fresh_reg) begin
        count_reg <= CNT_ONE;
        fresh_reg <= 1'b0;
      end else if (clr_pend_reg) begin
        count_reg    <= CNT_ZERO;
        clr_pend_reg <= 1'b0;
      end else begin
        count_reg    <= count_reg + 16'h0001;
        clr_pend_reg <= clr_src;
      end
    end
  end

  // second instance counter, reduced: count and overflow flag only, no outputs
  always_ff @(posedge i_clock) begin
    if (i_reset || !ce2) begin
      count2_reg <= CNT_ZERO;
      fresh2_reg <= 1'b1;
    end else if (tick2) begin
      count2_reg <= fresh2_reg ? CNT_ONE : count2_reg + 16'h0001;
      fresh2_reg <= 1'b0;
    end
  end

  // request pulses, one cycle after the match or pin edge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      irqx_reg <= 1'b0;
    end else begin
      irq0_reg <= match0;
      irq1_reg <= match1;
      irqx_reg <= pin_edge;
    end
  end

  // ****************************************************
  // output channels
  // ****************************************************
  // mode nibble picks waveform
  dct_channel u_ch0 (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_match    (match0),
    .i_overflow (wrap || (m0.programmable_pulse_mode && match1)),
    .i_stop     (!ce),
    .i_pwm      (m0.pwm),
    .i_ppg      (m0.programmable_pulse_mode),
    .i_enable   (outctl_reg[1]),
    .i_level    (outctl_reg[0]),
    .o_pin      (o_timer_output_0)
  );

  dct_channel u_ch1 (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_match    (match1),
    .i_overflow (wrap || (m1.programmable_pulse_mode && match0)),
    .i_stop     (!ce),
    .i_pwm      (m1.pwm),
    .i_ppg      (m1.programmable_pulse_mode),
    .i_enable   (outctl_reg[3]),
    .i_level    (outctl_reg[2]),
    .o_pin      (o_timer_output_1)
  );

  // ****************************************************
  // axi4-lite slave
  // ****************************************************
  logic        wr_go;
  logic [15:0] wr_idx;
  logic [15:0] rd_idx;
  logic        wr_ok;

  assign wr_go  = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = awaddr_reg[ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  assign wr_ok  = wr_idx inside {IDX_MODE, IDX_CTRL, IDX_CMP0, IDX_CMP1, IDX_OUTCTL,
                                 IDX_CLKSEL, IDX_EDGESEL, IDX_NOISE, IDX_CMP2, IDX_CMP3};

  // address and data capture in either order
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // register writes; byte lane 0 for bytes, lanes 0-1 for words
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_reg    <= 8'h00;
      outctl_reg  <= 8'h00;
      clksel_reg  <= 8'h00;
      edgesel_reg <= 2'h0;
      noise_reg   <= 1'b0;
      cmp0_reg    <= CMP_RESET;
      cmp1_reg    <= CMP_RESET;
      cmp2_reg    <= CMP_RESET;
      cmp3_reg    <= CMP_RESET;
    end else if (wr_go && wstrb_reg[0]) begin
      unique case (wr_idx)
        IDX_MODE:    mode_reg    <= wdata_reg[7:0];
        IDX_OUTCTL:  outctl_reg  <= wdata_reg[7:0];
        IDX_CLKSEL:  clksel_reg  <= wdata_reg[7:0];
        IDX_EDGESEL: edgesel_reg <= wdata_reg[1:0];
        IDX_NOISE:   noise_reg   <= wdata_reg[0];
        IDX_CMP0:    cmp0_reg    <= wstrb_reg[1] ? wdata_reg[15:0] : cmp0_reg;
        IDX_CMP1:    cmp1_reg    <= wstrb_reg[1] ? wdata_reg[15:0] : cmp1_reg;
        IDX_CMP2:    cmp2_reg    <= wstrb_reg[1] ? wdata_reg[15:0] : cmp2_reg;
        IDX_CMP3:    cmp3_reg    <= wstrb_reg[1] ? wdata_reg[15:0] : cmp3_reg;
        default:     mode_reg    <= mode_reg;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_reg <= 8'h00;
    end else begin
      if (wr_go && wstrb_reg[0] && wr_idx == IDX_CTRL) begin
        ctrl_reg <= wdata_reg[7:0] & CTRL_MASK;
      end
      if (wrap) begin
        ctrl_reg[OVF_BIT] <= 1'b1;
      end
      if (ce2 && tick2 && !fresh2_reg && count2_reg == CNT_FULL) begin
        ctrl_reg[SECOND_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // read channel, one-cycle answer
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (rd_idx)
        IDX_MODE:    rdata_reg <= {24'h000000, mode_reg};
        IDX_CTRL:    rdata_reg <= {24'h000000, ctrl_reg};
        IDX_COUNT:   rdata_reg <= {16'h0000, count_reg};
        IDX_CMP0:    rdata_reg <= {16'h0000, cmp0_reg};
        IDX_CMP1:    rdata_reg <= {16'h0000, cmp1_reg};
        IDX_OUTCTL:  rdata_reg <= {24'h000000, outctl_reg};
        IDX_CLKSEL:  rdata_reg <= {24'h000000, clksel_reg};
        IDX_EDGESEL: rdata_reg <= {30'h0, edgesel_reg};
        IDX_NOISE:   rdata_reg <= {31'h0, noise_reg};
        IDX_COUNT2:  rdata_reg <= {16'h0000, count2_reg};
        IDX_CMP2:    rdata_reg <= {16'h0000, cmp2_reg};
        IDX_CMP3:    rdata_reg <= {16'h0000, cmp3_reg};
        default: begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready       = !aw_held_reg;
  assign s_axi_wready        = !w_held_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = !rvalid_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign o_compare0_irq      = irq0_reg;
  assign o_compare1_irq      = irq1_reg;
  assign o_external_edge_irq = irqx_reg;
endmodule
`default_nettype wire

// >>> dct_timer_properties.sv
`default_nettype none
// ****************************************************
// port checker for the compare timer
// ****************************************************
module dct_timer_properties (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_reset,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pins and requests
  input wire logic        o_timer_output_0,
  input wire logic        o_timer_output_1,
  input wire logic        o_compare0_irq,
  input wire logic        o_compare1_irq,
  input wire logic        o_external_edge_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // fastest internal count clock is a quarter rate, so requests sit three quiet cycles apart
  sequence s_quiet0; !o_compare0_irq [*3]; endsequence
  sequence s_quiet1; !o_compare1_irq [*3]; endsequence
  sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  a_reset_pins_idle: assert property ($fell(i_reset) |-> o_timer_output_0 && o_timer_output_1)
    else $error("pins not idle high after reset");
  a_irq0_gap: assert property (o_compare0_irq |=> s_quiet0)
    else $error("compare 0 request too close");
  a_irq1_gap: assert property (o_compare1_irq |=> s_quiet1)
    else $error("compare 1 request too close");
  a_edge_irq_pulse: assert property (o_external_edge_irq |=> !o_external_edge_irq)
    else $error("edge request longer than one cycle");
  // both halves are held one cycle, response registered on the next
  a_write_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind dct_timer dct_timer_properties u_props (.*);
`default_nettype wire

// >>> dct_timer_tb.sv
`default_nettype none
module dct_timer_tb
  import dct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************
  // signals
  // ****************************************************
  logic              i_clock, i_reset, i_external_count_input, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic              s_axi_rvalid, o_timer_output_0, o_timer_output_1, o_compare0_irq, o_compare1_irq;
  logic              o_external_edge_irq, p1, p2;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [15:0]       cv;
  logic [33:0]       rq[$], bq[$];
  int                error_cnt = 0, n_tests = 0, cyc = 0, ne = 0, n0 = 0, n1 = 0, t1, t2;
  localparam logic [15:0] RI[6] = '{IDX_MODE, IDX_CTRL, IDX_COUNT, IDX_OUTCTL, IDX_CLKSEL, IDX_COUNT2};
  localparam int          EN[4] = '{4, 4, 0, 8};

  dct_timer dut (.*);

  // free running system clock
  initial begin
    i_clock = 0;
    forever #50 i_clock = ~i_clock;
  end

  // ****************************************************
  // checking
  // ****************************************************
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // responses against oldest notes, event counts, hang guard
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    ne <= ne + int'(o_external_edge_irq);
    n0 <= n0 + int'(o_compare0_irq);
    n1 <= n1 + int'(o_compare1_irq);
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, bq.pop_front());
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************************
  // bus tasks
  // ****************************************************
  // random ready stall exercises a held read response in axr; axw raises bready no later than bvalid, so no write response is held
  task automatic axw(input logic [15:0] i, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    logic a, w;
    a = 1;
    w = 1;
    bq.push_back({32'h0, e});
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (a | w) begin
      @(posedge i_clock);
      a = a & !s_axi_awready;
      w = w & !s_axi_wready;
      s_axi_awvalid <= a;
      s_axi_wvalid <= w;
    end
    repeat ($urandom_range(1)) @(posedge i_clock);
    s_axi_bready <= 1;
    do @(posedge i_clock); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask

  task automatic axr(input logic [15:0] i, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    rq.push_back({e, d});
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    do @(posedge i_clock); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    repeat ($urandom_range(1)) @(posedge i_clock);
    s_axi_rready <= 1;
    do @(posedge i_clock); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask

  // pin sampled two cycles after the request, once it has settled
  task automatic wirq(output int t, output logic p);
    do @(posedge i_clock); while (!o_compare0_irq);
    t = cyc;
    repeat (2) @(posedge i_clock);
    p = o_timer_output_0;
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    i_reset = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, i_external_count_input} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h55ed685e));
    repeat (10) @(posedge i_clock);
    i_reset <= 0;
    repeat (2) @(posedge i_clock);
    chk({32'h0, o_timer_output_1, o_timer_output_0}, 34'h3);
    foreach (RI[k]) axr(RI[k], 0);
    axw(IDX_CTRL, 32'hf0);
    axr(IDX_CTRL, 0);
    axr(16'hff40, 0, RESP_SLVERR);
    axw(16'hff40, 1, RESP_SLVERR);
    // disabled pins show the inverse of their level bits
    for (int l = 0; l < 4; l++) begin
      axw(IDX_OUTCTL, {28'h0, 1'b0, l[1], 1'b0, l[0]});
      repeat (2) @(posedge i_clock);
      chk({32'h0, ~2'(l)}, {32'h0, o_timer_output_1, o_timer_output_0});
    end
    axw(IDX_OUTCTL, 32'h2);
    axw(IDX_MODE, {28'h0, OM_TOG_C0});
    // every divider with a random compare-clear period
    for (int c = 0; c < 5; c++) begin
      cv = 16'($urandom_range(9, 2));
      axw(IDX_CTRL, 0);
      axr(IDX_COUNT, 0);
      axw(IDX_CMP0, {16'h0, cv});
      axr(IDX_CMP0, {16'h0, cv});
      axw(IDX_CMP1, {16'h0, cv});
      axr(IDX_CMP1, {16'h0, cv});
      axw(IDX_CLKSEL, 32'(c));
      axw(IDX_CTRL, 32'h2);
      wirq(t1, p1);
      axw(IDX_CTRL, 32'h2);
      wirq(t2, p2);
      chk(34'(t2 - t1), 34'((cv + 1) * (4 << c)));
      chk({33'h0, p2}, {33'h0, ~p1});
    end
    axw(IDX_CTRL, 0);
    t1 = n0;
    repeat (300) @(posedge i_clock);
    chk(34'(n0), 34'(t1));
    chk(34'(n1), 34'(n0));
    // each edge select code against four pulses
    for (int e = 0; e < 4; e++) begin
      axw(IDX_EDGESEL, 32'(e));
      t1 = ne;
      repeat (8) begin
        repeat (12) @(posedge i_clock);
        i_external_count_input <= ~i_external_count_input;
      end
      repeat (12) @(posedge i_clock);
      chk(34'(ne - t1), 34'(EN[e]));
    end
    finish_test();
  end
endmodule
`default_nettype wire
